// ===== test/uav_core_mem.sv
// Code memory seen by the core's vector fetch
`timescale 1ns/10ps
`default_nettype none
module uav_core_mem (
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_rdata
);
  // Jump opcode at both entry points; other bytes follow the address
  assign code_rdata = (code_addr == 16'h0043 || code_addr == 16'h0053) ?
                      8'h02 : code_addr[7:0] ^ 8'h3c;
endmodule // uav_core_mem
`default_nettype wire

// ===== test/uav_irq_properties.sv
// Port checker for the autovector interrupt controller
`timescale 1ns/10ps
`default_nettype none
module uav_irq_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [15:0] code_addr,
  input wire logic [7:0]  code_rdata,
  input wire logic [7:0]  code_fetch_byte,
  input wire logic        usb_shared_irq,
  input wire logic        fifo_shared_irq,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_jump;
    code_addr == 16'h0043 ##1 code_addr == 16'h0044;
  endsequence
  sequence s_pass;
    code_fetch_byte == $past(code_rdata);
  endsequence
  irq_merge_a: assert property (irq == (usb_shared_irq | fifo_shared_irq))
    else $error("irq merge");
  fetch_pass_a: assert property (
    code_addr != 16'h0045 && code_addr != 16'h0055 |=> s_pass)
    else $error("fetch pass");
  jump_page_a: assert property (s_jump |=> s_pass)
    else $error("jump page");
  usb_vec_a: assert property (code_addr == 16'h0045 |=>
    (code_fetch_byte[1:0] == 2'b00 && !code_fetch_byte[7]) ||
    code_fetch_byte == $past(code_rdata)) else $error("usb vector");
  usb_rsvd_a: assert property (code_addr == 16'h0045 |=>
    !(code_fetch_byte inside {8'h14, 8'h1c, 8'h44, 8'h68, 8'h6c}))
    else $error("usb reserved");
  fifo_vec_a: assert property (code_addr == 16'h0055 |=>
    (code_fetch_byte[1:0] == 2'b00 && code_fetch_byte >= 8'h80 &&
    code_fetch_byte <= 8'hb4) || code_fetch_byte == $past(code_rdata))
    else $error("fifo vector");
  usb_hold_a: assert property ($fell(usb_shared_irq) |-> $past(reg_wr))
    else $error("usb hold");
  fifo_hold_a: assert property ($fell(fifo_shared_irq) |-> $past(reg_wr))
    else $error("fifo hold");
endmodule // uav_irq_props
bind uav_irq uav_irq_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_wr(reg_wr), .code_addr(code_addr), .code_rdata(code_rdata),
  .code_fetch_byte(code_fetch_byte), .usb_shared_irq(usb_shared_irq),
  .fifo_shared_irq(fifo_shared_irq), .irq(irq));
`default_nettype wire

// ===== test/usb_fifo_irq_autovector_tb_top.sv
// Self-checking bench for the autovector interrupt controller
`timescale 1ns/10ps
`default_nettype none
module usb_fifo_irq_autovector_tb_top;
  localparam logic [31:0] usb_valid = 32'hf0fdff5f;
  logic        clk_sys, rst_n, reg_wr, reg_rd, bus_error;
  logic        usb_shared_irq, fifo_shared_irq, irq;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, usb_src;
  logic [13:0] fifo_src;
  logic [15:0] code_addr;
  logic [7:0]  code_rdata, code_fetch_byte;
  int          miscompares, cmp_count;
  uav_core_mem u_mem (.code_addr(code_addr), .code_rdata(code_rdata));
  uav_irq DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .setup_data_ready(usb_src[0]),
    .start_of_frame(usb_src[1]), .setup_token_seen(usb_src[2]),
    .usb_suspend(usb_src[3]), .usb_bus_reset(usb_src[4]),
    .control_handshake_acked(usb_src[6]),
    .ep01_in_ready({usb_src[10], usb_src[8]}),
    .ep01_out_data({usb_src[11], usb_src[9]}),
    .ep_buffer_event(usb_src[15:12]), .in_bulk_nak(usb_src[16]),
    .out_ping_nak(usb_src[23:18]), .bus_error(bus_error),
    .iso_pid_sequence_error(usb_src[31:28]),
    .programmable_level_flag(fifo_src[3:0]),
    .endpoint_empty_flag(fifo_src[7:4]), .endpoint_full_flag(fifo_src[11:8]),
    .waveform_engine_done(fifo_src[12]), .waveform_engine_event(fifo_src[13]),
    .code_addr(code_addr), .code_rdata(code_rdata),
    .code_fetch_byte(code_fetch_byte), .usb_shared_irq(usb_shared_irq),
    .fifo_shared_irq(fifo_shared_irq), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input string w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, w);
  endtask
  task fetch(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    code_addr <= a;
    @(posedge clk_sys);
    #1 chk({24'h0, code_fetch_byte}, {24'h0, e}, "fetch");
  endtask
  // Sources are pulsed for one cycle; status must stay latched afterwards
  task pulse(input logic [31:0] u, input logic [13:0] f);
    @(posedge clk_sys);
    usb_src <= u;
    fifo_src <= f;
    @(posedge clk_sys);
    usb_src <= 32'h0;
    fifo_src <= 14'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task t_reset;
    rd(4'h0, 32'h0, "setup");
    rd(4'h7, 32'h4, "limit");
    rd(4'h9, 32'h0, "unmapped");
    rd(4'h6, 32'h80, "fifo vec idle");
  endtask
  task t_codes;
    wr(4'h2, 32'hffffffff);
    wr(4'h4, 32'h3fff);
    for (int i = 0; i < 32; i++) begin
      if (!usb_valid[i]) continue;
      pulse(32'h1 << i, 14'h0);
      chk({31'h0, usb_shared_irq}, 32'h1, "usb irq");
      rd(4'h5, i * 4, "usb vec");
      wr(4'h1, 32'h1 << i);
    end
    for (int i = 0; i < 14; i++) begin
      pulse(32'h0, 14'h1 << i);
      chk({31'h0, irq}, 32'h1, "irq");
      rd(4'h6, 8'h80 + i * 4, "fifo vec");
      wr(4'h3, 32'h1 << i);
    end
    #1 chk({usb_shared_irq, fifo_shared_irq}, 32'h0, "irq idle");
  endtask
  task t_prio;
    wr(4'h0, 32'h3);
    pulse(32'h802, 14'h201);
    fetch(16'h0043, 8'h02);
    fetch(16'h0044, 8'h78);
    fetch(16'h0045, 8'h04);
    fetch(16'h0053, 8'h02);
    fetch(16'h0055, 8'h80);
    wr(4'h1, 32'h2);
    wr(4'h3, 32'h1);
    fetch(16'h0045, 8'h2c);
    fetch(16'h0055, 8'ha4);
    wr(4'h0, 32'h0);
    fetch(16'h0045, 8'h79);
    fetch(16'h0055, 8'h69);
    wr(4'h2, 32'h0);
    #1 chk({usb_shared_irq, irq}, 32'h1, "masked");
    rd(4'h1, 32'h800, "usb status");
    wr(4'h1, 32'h800);
    wr(4'h3, 32'h200);
  endtask
  // A limit of two: only the third error crosses it
  task t_errlim;
    wr(4'h7, 32'h2);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      bus_error <= 1'b1;
      @(posedge clk_sys);
      bus_error <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd(4'h1, (i == 2) ? 32'h01000000 : 32'h0, "err limit");
    end
    rd(4'h8, 32'h3, "err count");
    wr(4'h8, 32'h0);
    rd(4'h8, 32'h0, "err count clear");
  endtask
  task conclude;
    $display("Checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, bus_error, reg_addr} = 8'h0;
    {reg_wdata, usb_src, fifo_src, code_addr} = 94'h0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_codes;
    t_prio;
    t_errlim;
    conclude;
  end
  initial begin
    #2000000;
    miscompares++;
    conclude;
  end
endmodule // usb_fifo_irq_autovector_tb_top
`default_nettype wire

// ===== verilog/uav_irq.v
// Two-level interrupt autovector controller for the core's USB/FIFO sources
// Operation
// - Merge 26 USB sources and 14 FIFO sources into two shared requests
// - USB interrupt makes core push PC and branch to 0x0043
// - USB autovector on: byte at 0x0045 replaced by USB vector byte
// - FIFO interrupt makes core push PC and branch to 0x0053
// - FIFO autovector on: byte at 0x0055 replaced by FIFO vector byte
// - Control events coded 00,04,08,0C,10,18; 14 and 1C reserved
// - Endpoint 0/1 IN and OUT events coded 20 to 2C
// - Endpoint 2,4,6,8 buffer events coded 30 to 3C
// - Any IN endpoint NAK raises in-bulk-NAK, code 40
// - Ping NAK on endpoints 0,1,2,4,6,8 coded 48 to 5C
// - Error-limit source, code 60, when bus errors exceed programmed limit below 15; a limit of 15 never raises it
// - Iso PID sequence errors on endpoints 2,4,6,8 coded 70 to 7C
// - Programmable-level flags coded 80 to 8C, highest FIFO priority
// - Empty flags of endpoints 2,4,6,8 coded 90 to 9C
// - Full flags of endpoints 2,4,6,8 coded A0 to AC
// - Waveform engine done at B0, waveform event B4 lowest
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "uav_irq_regs.vh"

module uav_irq (
  input  wire        clk_sys,
  input  wire        rst_n,
  // Register bus
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // USB event sources
  input  wire        setup_data_ready,
  input  wire        start_of_frame,
  input  wire        setup_token_seen,
  input  wire        usb_suspend,
  input  wire        usb_bus_reset,
  input  wire        control_handshake_acked,
  input  wire [1:0]  ep01_in_ready,
  input  wire [1:0]  ep01_out_data,
  input  wire [3:0]  ep_buffer_event,
  input  wire        in_bulk_nak,
  input  wire [5:0]  out_ping_nak,
  input  wire        bus_error,
  input  wire [3:0]  iso_pid_sequence_error,
  // FIFO and waveform engine sources
  input  wire [3:0]  programmable_level_flag,
  input  wire [3:0]  endpoint_empty_flag,
  input  wire [3:0]  endpoint_full_flag,
  input  wire        waveform_engine_done,
  input  wire        waveform_engine_event,
  // Core code fetch
  input  wire [15:0] code_addr,
  input  wire [7:0]  code_rdata,
  output reg  [7:0]  code_fetch_byte,
  // Interrupt requests
  output wire        usb_shared_irq,
  output wire        fifo_shared_irq,
  output wire        irq
);

  // Slot n of the USB group carries vector code 4*n; reserved slots stay 0
  wire [31:0] usb_src;
  wire [13:0] fifo_src;
  wire [31:0] usb_stat;
  reg  [31:0] usb_mask;
  wire [13:0] fifo_stat;
  reg  [13:0] fifo_mask;
  reg  [1:0]  irq_setup_register;
  reg  [3:0]  err_limit;
  reg  [3:0]  err_count;
  reg         err_hit;
  reg  [7:0]  usb_vector_byte;
  reg  [7:0]  fifo_vector_byte;
  reg  [7:0]  next_usb_vec;
  reg  [7:0]  next_fifo_vec;
  reg  [7:0]  next_fetch;
  reg  [31:0] next_rdata;
  wire        usb_autovector_enable;
  wire        fifo_autovector_enable;
  wire [31:0] usb_pend;
  wire [13:0] fifo_pend;
  wire        wr_usb_stat;
  wire        wr_fifo_stat;
  wire        usb_vec_sel;
  wire        fifo_vec_sel;
  genvar      gu;
  genvar      gf;
  // Slots that carry a live source; the rest are reserved
  localparam [31:0] usb_live = `UAV_USB_SRC_MASK;

  assign usb_src[0]  = setup_data_ready;
  assign usb_src[1]  = start_of_frame;
  assign usb_src[2]  = setup_token_seen;
  assign usb_src[3]  = usb_suspend;
  assign usb_src[4]  = usb_bus_reset;
  assign usb_src[5]  = 1'b0;
  assign usb_src[6]  = control_handshake_acked;
  assign usb_src[7]  = 1'b0;
  assign usb_src[8]  = ep01_in_ready[0];
  assign usb_src[9]  = ep01_out_data[0];
  assign usb_src[10] = ep01_in_ready[1];
  assign usb_src[11] = ep01_out_data[1];
  assign usb_src[15:12] = ep_buffer_event;
  assign usb_src[16] = in_bulk_nak;
  assign usb_src[17] = 1'b0;
  assign usb_src[23:18] = out_ping_nak;
  assign usb_src[24] = err_hit;
  assign usb_src[27:25] = 3'h0;
  assign usb_src[31:28] = iso_pid_sequence_error;

  // FIFO slot n carries vector code 80 plus 4*n
  assign fifo_src[3:0]   = programmable_level_flag;
  assign fifo_src[7:4]   = endpoint_empty_flag;
  assign fifo_src[11:8]  = endpoint_full_flag;
  assign fifo_src[12]    = waveform_engine_done;
  assign fifo_src[13]    = waveform_engine_event;

  assign usb_autovector_enable  = irq_setup_register[`UAV_SETUP_USB_AV];
  assign fifo_autovector_enable = irq_setup_register[`UAV_SETUP_FIFO_AV];
  assign wr_usb_stat  = reg_wr && (reg_addr == `UAV_OFF_USB_STAT);
  assign wr_fifo_stat = reg_wr && (reg_addr == `UAV_OFF_FIFO_STAT);

  // Bus error counter; saturates rather than wrapping so a long error
  // burst cannot fake a fresh crossing of the limit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      err_count <= 4'h0;
    else if (reg_wr && reg_addr == `UAV_OFF_ERR_COUNT)
      err_count <= 4'h0;
    else if (bus_error && err_count != 4'hf)
      err_count <= err_count + 4'h1;
  end

  // One-cycle limit event from the error that takes the count past the
  // limit; the sticky status bit holds it afterwards
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      err_hit <= 1'b0;
    else
      err_hit <= bus_error && err_count != 4'hf &&
                 err_count == err_limit &&
                 !(reg_wr && reg_addr == `UAV_OFF_ERR_COUNT);
  end

  // Sticky status, write one to clear. A new event wins over a clear in
  // the same cycle, so an event landing during the clear is not lost
  generate
    for (gu = 0; gu < `UAV_USB_SLOTS; gu = gu + 1) begin : g_usb_bit
      if (usb_live[gu]) begin : g_live
        reg bit_q;
        always @(posedge clk_sys or negedge rst_n) begin
          if (!rst_n)
            bit_q <= 1'b0;
          else if (usb_src[gu])
            bit_q <= 1'b1;
          else if (wr_usb_stat && reg_wdata[gu])
            bit_q <= 1'b0;
        end
        assign usb_stat[gu] = bit_q;
      end else begin : g_rsvd
        // Reserved slot: nothing can set it, so it never vectors
        assign usb_stat[gu] = 1'b0;
      end
    end
    for (gf = 0; gf < `UAV_FIFO_SLOTS; gf = gf + 1) begin : g_fifo_bit
      reg bit_q;
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          bit_q <= 1'b0;
        else if (fifo_src[gf])
          bit_q <= 1'b1;
        else if (wr_fifo_stat && reg_wdata[gf])
          bit_q <= 1'b0;
      end
      assign fifo_stat[gf] = bit_q;
    end
  endgenerate

  // Autovector enables
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      irq_setup_register <= `UAV_SETUP_RST;
    else if (reg_wr && reg_addr == `UAV_OFF_SETUP)
      irq_setup_register <= reg_wdata[1:0];
  end

  // Reserved USB slots can never be enabled
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      usb_mask <= `UAV_MASK_RST;
    else if (reg_wr && reg_addr == `UAV_OFF_USB_MASK)
      usb_mask <= reg_wdata & `UAV_USB_SRC_MASK;
  end

  // FIFO enables
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      fifo_mask <= 14'h0000;
    else if (reg_wr && reg_addr == `UAV_OFF_FIFO_MASK)
      fifo_mask <= reg_wdata[13:0];
  end

  // Error limit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      err_limit <= `UAV_ERR_LIMIT_RST;
    else if (reg_wr && reg_addr == `UAV_OFF_ERR_LIMIT)
      err_limit <= reg_wdata[3:0];
  end

  assign usb_pend  = usb_stat & usb_mask;
  assign fifo_pend = fifo_stat & fifo_mask;
  assign usb_shared_irq  = |usb_pend;
  assign fifo_shared_irq = |fifo_pend;
  // Combined request for a core with a single interrupt input
  assign irq = usb_shared_irq | fifo_shared_irq;

  // Fixed priority: the first pending source in table order wins, and
  // table order is ascending code order
  // Reserved codes 14, 1c, 44, 64, 68 and 6c never appear here
  always @* begin
    next_usb_vec = `UAV_USB_VEC_BASE;
    if (usb_pend[0])
      next_usb_vec = 8'h00;
    else if (usb_pend[1])
      next_usb_vec = 8'h04;
    else if (usb_pend[2])
      next_usb_vec = 8'h08;
    else if (usb_pend[3])
      next_usb_vec = 8'h0c;
    else if (usb_pend[4])
      next_usb_vec = 8'h10;
    else if (usb_pend[6])
      next_usb_vec = 8'h18;
    else if (usb_pend[8])
      next_usb_vec = 8'h20;
    else if (usb_pend[9])
      next_usb_vec = 8'h24;
    else if (usb_pend[10])
      next_usb_vec = 8'h28;
    else if (usb_pend[11])
      next_usb_vec = 8'h2c;
    else if (usb_pend[12])
      next_usb_vec = 8'h30;
    else if (usb_pend[13])
      next_usb_vec = 8'h34;
    else if (usb_pend[14])
      next_usb_vec = 8'h38;
    else if (usb_pend[15])
      next_usb_vec = 8'h3c;
    else if (usb_pend[16])
      next_usb_vec = 8'h40;
    else if (usb_pend[18])
      next_usb_vec = 8'h48;
    else if (usb_pend[19])
      next_usb_vec = 8'h4c;
    else if (usb_pend[20])
      next_usb_vec = 8'h50;
    else if (usb_pend[21])
      next_usb_vec = 8'h54;
    else if (usb_pend[22])
      next_usb_vec = 8'h58;
    else if (usb_pend[23])
      next_usb_vec = 8'h5c;
    else if (usb_pend[24])
      next_usb_vec = 8'h60;
    else if (usb_pend[28])
      next_usb_vec = 8'h70;
    else if (usb_pend[29])
      next_usb_vec = 8'h74;
    else if (usb_pend[30])
      next_usb_vec = 8'h78;
    else if (usb_pend[31])
      next_usb_vec = 8'h7c;
  end

  // Level flags outrank empty and full flags; waveform event is last
  always @* begin
    next_fifo_vec = `UAV_FIFO_VEC_BASE;
    if (fifo_pend[0])
      next_fifo_vec = 8'h80;
    else if (fifo_pend[1])
      next_fifo_vec = 8'h84;
    else if (fifo_pend[2])
      next_fifo_vec = 8'h88;
    else if (fifo_pend[3])
      next_fifo_vec = 8'h8c;
    else if (fifo_pend[4])
      next_fifo_vec = 8'h90;
    else if (fifo_pend[5])
      next_fifo_vec = 8'h94;
    else if (fifo_pend[6])
      next_fifo_vec = 8'h98;
    else if (fifo_pend[7])
      next_fifo_vec = 8'h9c;
    else if (fifo_pend[8])
      next_fifo_vec = 8'ha0;
    else if (fifo_pend[9])
      next_fifo_vec = 8'ha4;
    else if (fifo_pend[10])
      next_fifo_vec = 8'ha8;
    else if (fifo_pend[11])
      next_fifo_vec = 8'hac;
    else if (fifo_pend[12])
      next_fifo_vec = 8'hb0;
    else if (fifo_pend[13])
      next_fifo_vec = 8'hb4;
  end

  // Vector bytes are registered so the fetched byte cannot glitch while a
  // new source arrives in the same cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      usb_vector_byte <= `UAV_USB_VEC_BASE;
    else
      usb_vector_byte <= next_usb_vec;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      fifo_vector_byte <= `UAV_FIFO_VEC_BASE;
    else
      fifo_vector_byte <= next_fifo_vec;
  end

  // Code fetch path: the core fetches the jump at 0x0043/0x0053 itself;
  // only the low target byte is swapped, page byte passes untouched
  assign usb_vec_sel  = usb_autovector_enable &&
                        (code_addr == `UAV_USB_LOW_ADDR);
  assign fifo_vec_sel = fifo_autovector_enable &&
                        (code_addr == `UAV_FIFO_LOW_ADDR);

  always @* begin
    next_fetch = code_rdata;
    if (usb_vec_sel)
      next_fetch = usb_vector_byte;
    else if (fifo_vec_sel)
      next_fetch = fifo_vector_byte;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      code_fetch_byte <= 8'h00;
    else
      code_fetch_byte <= next_fetch;
  end

  always @* begin
    case (reg_addr)
      `UAV_OFF_SETUP:     next_rdata = {30'h0, irq_setup_register};
      `UAV_OFF_USB_STAT:  next_rdata = usb_stat;
      `UAV_OFF_USB_MASK:  next_rdata = usb_mask;
      `UAV_OFF_FIFO_STAT: next_rdata = {18'h0, fifo_stat};
      `UAV_OFF_FIFO_MASK: next_rdata = {18'h0, fifo_mask};
      `UAV_OFF_USB_VEC:   next_rdata = {24'h0, usb_vector_byte};
      `UAV_OFF_FIFO_VEC:  next_rdata = {24'h0, fifo_vector_byte};
      `UAV_OFF_ERR_LIMIT: next_rdata = {28'h0, err_limit};
      `UAV_OFF_ERR_COUNT: next_rdata = {28'h0, err_count};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    // Read data stands one cycle and is zero otherwise, so a stale value
    // never passes for a fresh read
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

endmodule // uav_irq
`default_nettype wire

// ===== verilog/uav_irq_regs.vh
// Register offsets, field positions, reset values and vector codes
`ifndef UAV_IRQ_REGS_VH
`define UAV_IRQ_REGS_VH

`define UAV_ADDR_W          4
`define UAV_OFF_SETUP       4'h0
`define UAV_OFF_USB_STAT    4'h1
`define UAV_OFF_USB_MASK    4'h2
`define UAV_OFF_FIFO_STAT   4'h3
`define UAV_OFF_FIFO_MASK   4'h4
`define UAV_OFF_USB_VEC     4'h5
`define UAV_OFF_FIFO_VEC    4'h6
`define UAV_OFF_ERR_LIMIT   4'h7
`define UAV_OFF_ERR_COUNT   4'h8

`define UAV_SETUP_USB_AV    0
`define UAV_SETUP_FIFO_AV   1
`define UAV_SETUP_RST       2'h0
`define UAV_MASK_RST        32'h00000000
`define UAV_ERR_LIMIT_RST   4'h4

`define UAV_USB_SLOTS       32
`define UAV_FIFO_SLOTS      14
`define UAV_USB_SRC_MASK    32'hf1fdff5f
`define UAV_USB_ERRLIM_BIT  24

`define UAV_USB_VEC_BASE    8'h00
`define UAV_FIFO_VEC_BASE   8'h80

`define UAV_USB_JMP_ADDR    16'h0043
`define UAV_USB_PAGE_ADDR   16'h0044
`define UAV_USB_LOW_ADDR    16'h0045
`define UAV_FIFO_JMP_ADDR   16'h0053
`define UAV_FIFO_PAGE_ADDR  16'h0054
`define UAV_FIFO_LOW_ADDR   16'h0055

`endif
